// ==== src/sbrg_top.sv ====
// Purpose: serial port rate generator with axi4-lite registers
// Assumes: aclk is the core oscillator; receive_pin synchronous to aclk
// Notes: bit_tick is one pulse per bit period
//
// The AXI4-Lite interface to the registers and the register addresses were decided locally.

////////////////////////////////////////////////////////////////////////////////
// Function
// - timer is 8 bits by default, 16 bits when wide-counter select set
// - divisor pair value n sets the period of a free-running timer
// - synchronous mode ignores high-speed select; rate is clock over 4(n+1)
// - async, 8-bit, high-speed clear: rate is clock over 64(n+1)
// - async 8-bit fast or 16-bit slow: rate is clock over 16(n+1)
// - generator runs in async mode or as master; synchronous slave takes outside clock
// - any divisor byte write clears the timer at once
// - receive level decided by majority of three samples
// - timer counts core clock; software rewrites divisor on clock change
// - sync is bit 4, high-speed bit 2, wide-counter bit 3
module sbrg_top
  import sbrg_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic receive_pin,
  output logic bit_tick,
  output logic rx_level,
  output sbrg_mode_t mode
);

  logic aw_held;
  logic [AXI_AW-1:0] awaddr_q;
  logic w_held;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  sbrg_wr_state_t wr_state;
  logic wr_fire;
  logic wr_hit;
  logic cfg_wr;
  logic [7:0] transmit_status_control;
  logic [7:0] receive_status_control;
  logic [7:0] rate_control;
  logic [7:0] rate_divisor_high;
  logic [7:0] rate_divisor_low;
  logic [31:0] rd_word;
  logic rd_hit;
  logic [6:0] sel_div;
  logic [15:0] reload;
  logic run;
  logic [5:0] pre;
  logic pre_last;
  logic [15:0] rate_timer;
  logic [22:0] gap;
  logic armed;
  logic [2:0] warm;

  ////////////////////////////////////////////////////////////////////////////
  // write channel: address and data taken in either order

  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign wr_fire = aw_held && w_held && (wr_state == SBRG_WR_IDLE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      awaddr_q <= '0;
    end else if (s_axi_awvalid && !aw_held) begin
      aw_held <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (s_axi_wvalid && !w_held) begin
      w_held <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  always_comb begin
    case (awaddr_q)
      OFS_TSC, OFS_RSC, OFS_RC, OFS_DIVH, OFS_DIVL: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // status word is read-only, so a write to it is an error too
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state <= SBRG_WR_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      case (wr_state)
        SBRG_WR_IDLE: begin
          if (wr_fire) begin
            wr_state <= SBRG_WR_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
          end
        end
        SBRG_WR_RESP: begin
          if (s_axi_bready) begin
            wr_state <= SBRG_WR_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        end
        default: begin
          wr_state <= SBRG_WR_IDLE;
          s_axi_bvalid <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers, low byte lane only

  // mode or divisor change restarts the timer so no stale period runs out
  assign cfg_wr = wr_fire && (awaddr_q == OFS_TSC || awaddr_q == OFS_RC ||
    awaddr_q == OFS_DIVH || awaddr_q == OFS_DIVL);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      transmit_status_control <= TSC_RESET;
      receive_status_control <= RSC_RESET;
      rate_control <= RC_RESET;
      rate_divisor_high <= DIVH_RESET;
      rate_divisor_low <= DIVL_RESET;
    end else if (wr_fire && wstrb_q[0]) begin
      case (awaddr_q)
        OFS_TSC: transmit_status_control <= wdata_q[7:0];
        OFS_RSC: receive_status_control <= wdata_q[7:0];
        OFS_RC: rate_control <= wdata_q[7:0] & RC_WMASK;
        OFS_DIVH: rate_divisor_high <= wdata_q[7:0];
        OFS_DIVL: rate_divisor_low <= wdata_q[7:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    mode.master = transmit_status_control[TSC_MASTER_BIT];
    mode.sync = transmit_status_control[TSC_SYNC_BIT];
    mode.high = transmit_status_control[TSC_HIGH_BIT];
    mode.wide = rate_control[RC_WIDE_BIT];
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel

  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    rd_hit = 1'b1;
    rd_word = '0;
    case (s_axi_araddr)
      OFS_TSC: rd_word[7:0] = transmit_status_control;
      OFS_RSC: rd_word[7:0] = receive_status_control;
      OFS_RC: rd_word[7:0] = rate_control;
      OFS_DIVH: rd_word[7:0] = rate_divisor_high;
      OFS_DIVL: rd_word[7:0] = rate_divisor_low;
      OFS_STAT: begin
        rd_word[15:0] = rate_timer;
        rd_word[STAT_LEVEL_BIT] = rx_level;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // prescale selection

  always_comb begin
    if (mode.sync) begin
      sel_div = DIV_SYNC;
    end else if (mode.wide && mode.high) begin
      sel_div = DIV_SYNC;
    end else if (mode.wide || mode.high) begin
      sel_div = DIV_FAST;
    end else begin
      sel_div = DIV_SLOW;
    end
  end

  // narrow timer sees only the low divisor byte
  assign reload = mode.wide ? {rate_divisor_high, rate_divisor_low} :
    {8'h00, rate_divisor_low};

  // slave in synchronous mode: bit clock comes from the far end
  assign run = !mode.sync || mode.master;

  assign pre_last = (pre == 6'(sel_div - 7'h01));

  ////////////////////////////////////////////////////////////////////////////
  // rate timer, counts core clock cycles through the prescaler

  always_ff @(posedge aclk) begin
    if (!aresetn || cfg_wr || !run) begin
      pre <= '0;
    end else if (pre_last) begin
      pre <= '0;
    end else begin
      pre <= pre + 6'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || cfg_wr || !run) begin
      rate_timer <= '0;
    end else if (pre_last) begin
      if (rate_timer == 16'h0000) begin
        rate_timer <= reload;
      end else begin
        rate_timer <= rate_timer - 16'h0001;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bit_tick <= 1'b0;
    end else begin
      bit_tick <= run && !cfg_wr && pre_last &&
        (rate_timer == 16'h0000);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive pin majority

  sbrg_vote u_vote (
    .aclk(aclk),
    .aresetn(aresetn),
    .sample_in(receive_pin),
    .level(rx_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // helpers read only by the checks below

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap <= '0;
    end else if (bit_tick) begin
      gap <= 23'h000001;
    end else begin
      gap <= gap + 23'h000001;
    end
  end

  // first tick after a restart has a short gap; skip it
  always_ff @(posedge aclk) begin
    if (!aresetn || cfg_wr) begin
      armed <= 1'b0;
    end else if (bit_tick) begin
      armed <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      warm <= '0;
    end else if (warm != 3'h4) begin
      warm <= warm + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  AST_SYNC_RATE: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (bit_tick && armed && mode.sync) |->
      gap == (({7'h00, reload} + 23'h000001) << 2))
    else $error("sync bit period not 4(n+1)");

  AST_ASYNC_SLOW_RATE: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (bit_tick && armed && !mode.sync && !mode.wide && !mode.high) |->
      gap == (({7'h00, reload} + 23'h000001) << 6))
    else $error("async slow bit period not 64(n+1)");

  AST_ASYNC_MID_RATE: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (bit_tick && armed && !mode.sync && (mode.wide != mode.high)) |->
      gap == (({7'h00, reload} + 23'h000001) << 4))
    else $error("async mid bit period not 16(n+1)");

  AST_ASYNC_FAST_RATE: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (bit_tick && armed && !mode.sync && mode.wide && mode.high) |->
      gap == (({7'h00, reload} + 23'h000001) << 2))
    else $error("async fast bit period not 4(n+1)");

  AST_DIV_CLEAR: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (wr_fire && (awaddr_q == OFS_DIVH || awaddr_q == OFS_DIVL)) |=>
      (rate_timer == 16'h0000 && pre == 6'h00 && !bit_tick))
    else $error("divisor write did not clear timer");

  AST_SLAVE_QUIET: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (mode.sync && !mode.master) |=> !bit_tick)
    else $error("tick produced in synchronous slave mode");

  AST_NARROW_TIMER: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !mode.wide |-> rate_timer[15:8] == 8'h00)
    else $error("narrow timer used high byte");

  AST_WIDE_BIT: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (wr_fire && wstrb_q[0] && awaddr_q == OFS_RC) |=>
      mode.wide == $past(wdata_q[RC_WIDE_BIT]))
    else $error("wide-counter select not bit 3");

  AST_VOTE: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (warm == 3'h4) |-> rx_level ==
      (($past(receive_pin, 2) & $past(receive_pin, 3)) |
       ($past(receive_pin, 2) & $past(receive_pin, 4)) |
       ($past(receive_pin, 3) & $past(receive_pin, 4))))
    else $error("receive level not majority of three samples");

endmodule

// ==== src/sbrg_pkg.sv ====
// Purpose: shared constants and types for the serial rate generator
// Assumes: 32-bit axi4-lite register bus, one register per aligned word
// Notes: reset values of the control bytes are all zero

package sbrg_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register byte addresses
  localparam int AXI_AW = 8;
  localparam logic [7:0] OFS_TSC = 8'h00;
  localparam logic [7:0] OFS_RSC = 8'h04;
  localparam logic [7:0] OFS_RC = 8'h08;
  localparam logic [7:0] OFS_DIVH = 8'h0c;
  localparam logic [7:0] OFS_DIVL = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int TSC_MASTER_BIT = 7;
  localparam int TSC_SYNC_BIT = 4;
  localparam int TSC_HIGH_BIT = 2;
  localparam int RC_WIDE_BIT = 3;
  localparam int STAT_LEVEL_BIT = 16;

  ////////////////////////////////////////////////////////////////////////////
  // reset values and masks
  localparam logic [7:0] TSC_RESET = 8'h00;
  localparam logic [7:0] RSC_RESET = 8'h00;
  localparam logic [7:0] RC_RESET = 8'h00;
  localparam logic [7:0] DIVH_RESET = 8'h00;
  localparam logic [7:0] DIVL_RESET = 8'h00;
  localparam logic [7:0] RC_WMASK = 8'h1b;
  localparam logic [2:0] VOTE_RESET = 3'h7;

  ////////////////////////////////////////////////////////////////////////////
  // prescale factors ahead of the rate timer
  localparam logic [6:0] DIV_SLOW = 7'h40;
  localparam logic [6:0] DIV_FAST = 7'h10;
  localparam logic [6:0] DIV_SYNC = 7'h04;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic master;
    logic sync;
    logic wide;
    logic high;
  } sbrg_mode_t;

  typedef enum {
    SBRG_WR_IDLE,
    SBRG_WR_RESP
  } sbrg_wr_state_t;

endpackage

// ==== src/sbrg_vote.sv ====
// Purpose: three-sample majority decision on the receive pin
// Assumes: pin already synchronous to aclk
// Notes: idles high, as a serial line does

module sbrg_vote
  import sbrg_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sample_in,
  output logic level
);

  logic [2:0] samples;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      samples <= VOTE_RESET;
    end else begin
      samples <= {samples[1:0], sample_in};
    end
  end

  // one odd sample never flips the decision
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level <= 1'b1;
    end else begin
      level <= (samples[0] & samples[1]) | (samples[0] & samples[2]) |
        (samples[1] & samples[2]);
    end
  end

endmodule

// ==== dv/sbrg_top_tb.sv ====
// Purpose: self-checking bench for the serial rate generator over axi4-lite
// Assumes: bench drives every port itself; inputs change by nba at rising edges
// Notes: tick spacing is counted in aclk cycles, edges read before updates land

module sbrg_top_tb
  import sbrg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [AXI_AW-1:0] s_axi_awaddr = '0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [AXI_AW-1:0] s_axi_araddr = '0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic receive_pin = 1'b1;
  logic bit_tick;
  logic rx_level;
  sbrg_mode_t mode;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;

  always #20 aclk = ~aclk;

  sbrg_top dut_u (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .receive_pin(receive_pin),
    .bit_tick(bit_tick), .rx_level(rx_level), .mode(mode)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("mismatches %0d checks %0d", n_mismatch, num_checks);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // whole run needs about 7.5k cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_mismatch++;
      summarize();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // bus tasks: entered and left just after a rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    bit ad;
    bit wd;
    ad = 0;
    wd = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // no local limit: only the bench timeout may end a bus wait
    do begin
      @(posedge aclk);
      if (!ad && s_axi_awready === 1'b1) begin
        ad = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wd && s_axi_wready === 1'b1) begin
        wd = 1;
        s_axi_wvalid <= 1'b0;
      end
    end while (!(ad && wd));
    do begin
      @(posedge aclk);
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
    end while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do begin
      @(posedge aclk);
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, exp);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
    @(posedge aclk);
  endtask

  task automatic wait_tick(input int lim, output int n);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (bit_tick !== 1'b1 && n < lim);
  endtask

  // divisor high 01, low 02: narrow n=2, wide n=258
  task automatic run_mode(input logic [7:0] tsc, input logic [7:0] rc,
                          input int k, input int p);
    int n;
    wr(OFS_DIVH, 32'h01, 4'hf, RESP_OKAY);
    wr(OFS_DIVL, 32'h02, 4'hf, RESP_OKAY);
    wr(OFS_RC, {24'h0, rc}, 4'hf, RESP_OKAY);
    wr(OFS_TSC, {24'h0, tsc}, 4'hf, RESP_OKAY);
    if (p == 0) begin
      wait_tick(400, n);
      chk(n, 400);
    end else begin
      wait_tick(k + 2, n);
      chk({31'h0, n >= k - 3 && n <= k + 1}, 32'h1);
      wait_tick(p + 2, n);
      chk(n, p);
      // restart mid-period, new tick must not wait out the old period
      repeat (5) @(posedge aclk);
      wr(OFS_DIVL, 32'h02, 4'hf, RESP_OKAY);
      wait_tick(k + 2, n);
      chk({31'h0, n >= k - 3 && n <= k + 1}, 32'h1);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int n;
    int lows;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({28'h0, mode}, 32'h0);
    chk({31'h0, rx_level}, 32'h1);
    for (int i = 0; i < 5; i++) begin
      rd(8'(i * 4), 32'h0, RESP_OKAY);
    end
    // reset state: async slow narrow, n=0
    wait_tick(100, n);
    wait_tick(100, n);
    chk(n, 64);
    // control bits and write mask
    wr(OFS_RC, 32'hffff_ffff, 4'hf, RESP_OKAY);
    rd(OFS_RC, 32'h1b, RESP_OKAY);
    wr(OFS_TSC, 32'h94, 4'hf, RESP_OKAY);
    rd(OFS_TSC, 32'h94, RESP_OKAY);
    chk({28'h0, mode}, 32'hf);
    wr(OFS_RSC, 32'hffff_ffa5, 4'hf, RESP_OKAY);
    wr(OFS_RSC, 32'h5a, 4'h0, RESP_OKAY);
    rd(OFS_RSC, 32'ha5, RESP_OKAY);
    wr(8'h18, 32'h1, 4'hf, RESP_SLVERR);
    rd(8'h18, 32'h0, RESP_SLVERR);
    wr(OFS_STAT, 32'h1, 4'hf, RESP_SLVERR);
    // wide and fast settings chosen for low error and slow rates
    run_mode(8'h00, 8'h00, 64, 192);
    run_mode(8'h04, 8'h00, 16, 48);
    run_mode(8'h00, 8'h08, 16, 4144);
    run_mode(8'h04, 8'h08, 4, 1036);
    run_mode(8'h94, 8'h00, 4, 12);
    run_mode(8'h90, 8'h08, 4, 1036);
    run_mode(8'h10, 8'h00, 4, 0);
    // one-cycle glitch is outvoted, a held low is not
    lows = 0;
    receive_pin <= 1'b0;
    @(posedge aclk);
    receive_pin <= 1'b1;
    repeat (8) begin
      @(posedge aclk);
      if (rx_level !== 1'b1) lows++;
    end
    chk(lows, 0);
    receive_pin <= 1'b0;
    repeat (8) @(posedge aclk);
    chk({31'h0, rx_level}, 32'h0);
    // slave mode holds the timer at zero, so the status word is exact
    rd(OFS_STAT, 32'h0000_0000, RESP_OKAY);
    receive_pin <= 1'b1;
    repeat (8) @(posedge aclk);
    chk({31'h0, rx_level}, 32'h1);
    rd(OFS_STAT, 32'h1 << STAT_LEVEL_BIT, RESP_OKAY);
    summarize();
  end

endmodule
